/* tb/adcc_core_model.sv */
// Purpose: behavioural analog core feeding the converter sample
// Assumes: design samples conv_sample in the cycle before it pulses conv_irq
// Notes:   value steps after each completion so stale reads show up
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       arst_n,
	// converter side
	input  wire logic       conv_irq,
	output logic      [9:0] conv_sample
);
	// a fresh code per completion, never repeats within a short run
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			conv_sample <= 10'h2C5;
		else if (conv_irq)
			conv_sample <= conv_sample + 10'h137;
	end
endmodule
`default_nettype wire

/* tb/tb_adc_control_and_result_regs.sv */
// Purpose: self-checking bench for converter control and results
// Assumes: zero-wait APB slave, core model steps its sample
// Notes:   full documented counts are used, run near 16.5k cycles
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_and_result_regs
	import adcc_pkg::*;
;
	logic        mclk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic [ADCC_ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [9:0]  conv_sample, cur_s, last_s, s;
	logic [3:0]  conv_channel;
	logic        conv_start, conv_int_ref_en, conv_powered, conv_irq, erv;
	int          n_errors, num_checks, c, n_start, ns;

	adcc_top DUT (.mclk(mclk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv_sample(conv_sample),
		.conv_start(conv_start), .conv_channel(conv_channel),
		.conv_int_ref_en(conv_int_ref_en),
		.conv_powered(conv_powered), .conv_irq(conv_irq));
	adcc_core_model core (.mclk(mclk), .arst_n(arst_n),
		.conv_irq(conv_irq), .conv_sample(conv_sample));

	// clock
	always #2 mclk = ~mclk;

	// start pulses seen on the converter side
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			n_start <= 0;
		else if (conv_start === 1'h1)
			n_start <= n_start + 1;
	end

	// mirror of the sample the design should have captured
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cur_s <= 10'h2C5;
		end else if (conv_irq === 1'h1) begin
			last_s <= cur_s;
			cur_s  <= cur_s + 10'h137;
		end
	end

	task automatic chk(input logic [31:0] got, exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// one APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge mclk);
		psel    <= 1'h1;
		pwrite  <= wr;
		paddr   <= {a, 2'h0}; // word index to byte address
		pwdata  <= wd;
		@(posedge mclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdv = prdata;
		erv = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			chk(0, 1, "no pready");
			end_of_test();
		end
	endtask

	// bounded wait for a completion pulse, c holds the cycles waited
	task automatic wirq();
		c = 0;
		do begin
			@(posedge mclk);
			c++;
		end while (conv_irq !== 1'h1 && c < 6000);
		if (conv_irq !== 1'h1) begin
			chk(0, 1, "no completion");
			end_of_test();
		end
	endtask

	initial begin
		mclk = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; n_errors = 0; num_checks = 0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'h1;
		apb(0, ADCC_OFF_CTRL, 0);
		chk(rdv[7:0], ADCC_CTRL_RESET, "ctrl reset");
		chk(conv_int_ref_en, 0, "ref at reset");
		// every valid channel code, reference toggled alongside
		for (int i = 0; i < 5; i++) begin
			apb(1, ADCC_OFF_CTRL, {26'h0, i[0], 1'h0, i[3:0]});
			repeat (2) @(posedge mclk);
			chk(conv_channel, i[3:0], "channel");
			chk(conv_int_ref_en, !i[0], "ref select");
		end
		$display("test channels done");
		apb(1, ADCC_OFF_CTRL, 32'h83);
		apb(0, ADCC_OFF_CTRL, 0);
		chk(rdv[7], 1, "go busy");
		wirq();
		chk(c >= ADCC_SINGLE_CYCLES - 8 && c <= ADCC_SINGLE_CYCLES
			+ ADCC_WAKE_CYCLES, 1, "single length");
		apb(0, ADCC_OFF_CTRL, 0);
		chk(rdv[7], 0, "go cleared");
		apb(0, ADCC_OFF_UPPER, 0);
		chk(rdv[7:0], last_s[9:2], "upper");
		apb(0, ADCC_OFF_LOWER, 0);
		chk(rdv[7:6], last_s[1:0], "lower");
		repeat (170) @(posedge mclk);
		chk(conv_powered, 0, "idle power down");
		$display("test single done");
		// restart: a non-restarting core would finish far too early
		ns = n_start;
		apb(1, ADCC_OFF_CTRL, 32'h82);
		repeat (300) @(posedge mclk);
		apb(1, ADCC_OFF_CTRL, 32'h02);
		apb(0, ADCC_OFF_CTRL, 0);
		chk(rdv[7], 1, "zero write ignored");
		apb(1, ADCC_OFF_CTRL, 32'h82);
		wirq();
		chk(c >= ADCC_SINGLE_CYCLES - 4, 1, "restart");
		chk(n_start - ns, 2, "one start per go");
		$display("test restart done");
		apb(1, ADCC_OFF_CTRL, 32'h91);
		wirq();
		wirq();
		chk(c, ADCC_REPEAT_CYCLES, "period");
		apb(0, ADCC_OFF_CTRL, 0);
		chk(rdv[7], 0, "go after first");
		apb(0, ADCC_OFF_UPPER, 0);
		chk(rdv[7:0], last_s[9:2], "upper latest");
		s = last_s;
		wirq();
		apb(0, ADCC_OFF_LOWER, 0);
		chk(rdv[7:6], s[1:0], "lower kept");
		apb(1, ADCC_OFF_CTRL, 32'h01);
		$display("test repeat done");
		apb(1, ADCC_OFF_UPPER, 32'hFF);
		chk(erv, 1, "ro write");
		apb(0, 12'hF74, 0);
		chk(erv, 1, "unmapped");
		apb(0, ADCC_OFF_CTRL, 0);
		chk(erv, 0, "mapped");
		$display("test errors done");
		end_of_test();
	end
endmodule
`default_nettype wire

/* verilog/adcc_core_if.sv */
// Purpose: abstract converter core handshake, counts conversion time
// Assumes: one clock; start pulse restarts any conversion in flight
// Notes:   sample value comes from the analog side as a plain input
`timescale 1ns/1ps
`default_nettype none
module adcc_core_if
	import adcc_pkg::*;
#(
	parameter int CNT_W = ADCC_CNT_W
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// control
	input  wire logic              start,
	input  wire logic              abort,
	input  wire logic [CNT_W-1:0]  length,
	// completion
	output logic                   done
);
	logic [CNT_W-1:0] cnt_q;
	logic             run_q;

	// one counter per conversion; done is seen length edges after start
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				run_q <= 1'b0;
			end else if (start) begin
				cnt_q <= length - CNT_W'(1);
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q == CNT_W'(1)) begin
					done  <= 1'b1;
					run_q <= 1'b0;
				end else begin
					cnt_q <= cnt_q - CNT_W'(1);
				end
			end
		end
	end
endmodule
`default_nettype wire

/* verilog/adcc_pkg.sv */
// Purpose: shared constants for the converter control block
// Assumes: APB with 32-bit data, 250 MHz mclk
// Notes:   offsets are word indices; byte address is four times the index
package adcc_pkg;
	// register map as word indices; the low two address bits stay zero
	localparam int          ADCC_ADDR_W    = 14;
	localparam logic [11:0] ADCC_OFF_CTRL  = 12'hF70;
	localparam logic [11:0] ADCC_OFF_UPPER = 12'hF72;
	localparam logic [11:0] ADCC_OFF_LOWER = 12'hF73;
	// control field positions
	localparam int ADCC_BIT_GO     = 7;
	localparam int ADCC_BIT_RSVD   = 6;
	localparam int ADCC_BIT_REFSEL = 5;
	localparam int ADCC_BIT_REPEAT = 4;
	localparam int ADCC_CH_MSB     = 3;
	localparam int ADCC_CH_LSB     = 0;
	localparam logic [7:0] ADCC_CTRL_RESET = 8'h20;
	localparam logic [3:0] ADCC_CH_LAST    = 4'h4;
	// timing in system clock cycles
	localparam int ADCC_SINGLE_CYCLES = 5129;
	localparam int ADCC_REPEAT_CYCLES = 256;
	localparam int ADCC_IDLE_CYCLES   = 160;
	localparam int ADCC_WAKE_CYCLES   = 40;
	localparam int ADCC_CNT_W         = 13;
	// sequencer states
	typedef enum logic [3:0] {
		ADCC_IDLE = 4'b0001,
		ADCC_WAKE = 4'b0010,
		ADCC_CONV = 4'b0100,
		ADCC_RPT  = 4'b1000
	} adcc_state_t;
endpackage

/* verilog/adcc_top.sv */
// Purpose: converter control and result registers behind APB
// Assumes: analog core delivers its 10-bit sample on conv_sample
// Notes:   results stay unreset so they show unknown until a conversion
//
// How it works
// - writing go bit starts a conversion
// - go write while busy restarts conversion
// - go=0 ignored; reads 1 until done
// - refsel 0 enables internal reference
// - single shot finishes after 5129 cycles
// - repeat mode refreshes result every 256
// - channel codes 0-4 valid, others reserved
// - upper byte plus two lower bits
// - upper read latches the two low bits
// - lower read returns bits of last upper
// - upper invalid during single-shot conversion
// - repeat mode holds latest completed result
// - result registers have no reset value
// - six low bits of lower undefined
// - every completion pulses interrupt request (none if a go write lands on it)
// - idle 160 cycles powers converter down
// - wake from power down takes 40 cycles
// - repeat mode clears go after first
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
	import adcc_pkg::*;
(
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   arst_n,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [ADCC_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// converter core
	input  wire logic [9:0]             conv_sample,
	output logic                        conv_start,
	output logic      [3:0]             conv_channel,
	output logic                        conv_int_ref_en,
	output logic                        conv_powered,
	output logic                        conv_irq
);
	logic              go_q;
	logic              refsel_q;
	logic              repeat_q;
	logic [3:0]        chan_q;
	adcc_state_t       state_q;
	logic [7:0]        idle_q;
	logic [5:0]        wake_q;
	logic              powered_q;
	logic              first_done_q;
	logic [9:0]        result_q;
	logic [1:0]        low_latch_q;
	logic              core_start;
	logic              core_done;
	logic [ADCC_CNT_W-1:0] core_len;
	logic              sample_valid;

	// decode shared by read and write paths
	function automatic logic hit(input logic [ADCC_ADDR_W-1:0] a,
		input logic [11:0] o);
		return a == {o, 2'h0};
	endfunction

	wire access    = psel && penable;
	wire wr_ctrl   = access && pwrite && hit(paddr, ADCC_OFF_CTRL);
	wire rd_upper  = access && !pwrite && hit(paddr, ADCC_OFF_UPPER);
	wire go_write  = wr_ctrl && pwdata[ADCC_BIT_GO];

	// zero-wait slave; unmapped or wrong-direction access flags an error
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !(hit(paddr, ADCC_OFF_CTRL) ||
				(!pwrite && (hit(paddr, ADCC_OFF_UPPER) ||
				hit(paddr, ADCC_OFF_LOWER))));
		end
	end

	// pready registered from setup, so the access phase completes on its 1st edge
	wire go_now   = go_write && pready;
	wire wr_now   = wr_ctrl && pready;

	// configuration fields; bit 6 is not stored, reads as zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			refsel_q <= ADCC_CTRL_RESET[ADCC_BIT_REFSEL];
			repeat_q <= ADCC_CTRL_RESET[ADCC_BIT_REPEAT];
			chan_q   <= ADCC_CTRL_RESET[ADCC_CH_MSB:ADCC_CH_LSB];
		end else if (wr_now) begin
			refsel_q <= pwdata[ADCC_BIT_REFSEL];
			repeat_q <= pwdata[ADCC_BIT_REPEAT];
			chan_q   <= pwdata[ADCC_CH_MSB:ADCC_CH_LSB];
		end
	end

	// go bit: set by a 1 write, cleared at first completion; set wins
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			go_q <= 1'b0;
		end else if (go_now) begin
			go_q <= 1'b1;
		end else if (core_done && !first_done_q) begin
			go_q <= 1'b0;
		end
	end

	// sequencer: wake, first conversion, then repeat periods
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q      <= ADCC_IDLE;
			wake_q       <= '0;
			first_done_q <= 1'b0;
		end else if (go_now) begin
			first_done_q <= 1'b0;
			if (powered_q) begin
				state_q <= ADCC_CONV;
			end else begin
				state_q <= ADCC_WAKE;
				wake_q  <= 6'(ADCC_WAKE_CYCLES - 1);
			end
		end else begin
			case (state_q)
			ADCC_WAKE: begin
				if (wake_q == '0) begin
					state_q <= ADCC_CONV;
				end else begin
					wake_q <= wake_q - 6'd1;
				end
			end
			ADCC_CONV: begin
				if (core_done) begin
					first_done_q <= 1'b1;
					state_q <= repeat_q ? ADCC_RPT : ADCC_IDLE;
				end
			end
			ADCC_RPT: begin
				if (!repeat_q) begin
					state_q <= ADCC_IDLE;
				end
			end
			default: begin
				state_q <= ADCC_IDLE;
			end
			endcase
		end
	end

	// start the core on entry to a conversion and each repeat period
	assign core_start = (state_q == ADCC_WAKE && wake_q == '0 && !go_now)
		|| (go_now && powered_q)
		|| (core_done && repeat_q && state_q != ADCC_IDLE && !go_now);
	// a restart always runs a full first conversion, even mid-run
	assign core_len = (!go_now && (state_q == ADCC_RPT ||
		(state_q == ADCC_CONV && core_done)))
		? ADCC_CNT_W'(ADCC_REPEAT_CYCLES)
		: ADCC_CNT_W'(ADCC_SINGLE_CYCLES);

	adcc_core_if #(
		.CNT_W (ADCC_CNT_W)
	) u_core (
		.mclk   (mclk),
		.arst_n (arst_n),
		.start  (core_start),
		.abort  (state_q == ADCC_RPT && !repeat_q),
		.length (core_len),
		.done   (core_done)
	);

	// a done is only honoured when no restart overtakes it
	assign sample_valid = core_done && !go_now;

	// idle counter drives automatic power down
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			idle_q    <= '0;
			powered_q <= 1'b0;
		end else if (go_now || state_q != ADCC_IDLE) begin
			idle_q    <= '0;
			powered_q <= 1'b1;
		end else if (idle_q == 8'(ADCC_IDLE_CYCLES - 1)) begin
			powered_q <= 1'b0;
		end else begin
			idle_q <= idle_q + 8'd1;
		end
	end

	// results carry no reset, so they read unknown until written
	always_ff @(posedge mclk) begin
		if (sample_valid) begin
			result_q <= conv_sample;
		end
	end

	// upper read captures the low bits on its access edge, one edge after the upper byte is sampled
	always_ff @(posedge mclk) begin
		if (rd_upper && pready) begin
			low_latch_q <= result_q[1:0];
		end
	end

	// read mux; unused low bits of the lower register left unknown
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			if (hit(paddr, ADCC_OFF_CTRL)) begin
				prdata <= {24'h000000, go_q, 1'b0, refsel_q, repeat_q,
					chan_q};
			end else if (hit(paddr, ADCC_OFF_UPPER)) begin
				prdata <= {24'h000000, result_q[9:2]};
			end else if (hit(paddr, ADCC_OFF_LOWER)) begin
				prdata <= {24'h000000, low_latch_q, 6'bxxxxxx};
			end else begin
				prdata <= '0;
			end
		end
	end

	// core side outputs, all registered
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			conv_start      <= 1'b0;
			conv_channel    <= ADCC_CTRL_RESET[ADCC_CH_MSB:ADCC_CH_LSB];
			conv_int_ref_en <= 1'b0;
			conv_powered    <= 1'b0;
			conv_irq        <= 1'b0;
		end else begin
			conv_start      <= core_start;
			conv_channel    <= chan_q;
			conv_int_ref_en <= !refsel_q;
			conv_powered    <= powered_q;
			conv_irq        <= sample_valid;
		end
	end

	// assertions
	property p_go_sets;
		@(posedge mclk) disable iff (!arst_n)
		go_now |=> go_q;
	endproperty
	a_go_sets: assert property (p_go_sets) else $error("go not set");

	property p_irq_follows_done;
		@(posedge mclk) disable iff (!arst_n)
		sample_valid |=> conv_irq;
	endproperty
	a_irq_follows_done: assert property (p_irq_follows_done)
		else $error("no irq");

	property p_ref;
		@(posedge mclk) disable iff (!arst_n)
		##1 conv_int_ref_en == !$past(refsel_q);
	endproperty
	a_ref: assert property (p_ref) else $error("ref wrong");

	property p_go_stays;
		@(posedge mclk) disable iff (!arst_n)
		(go_q && !core_done) |=> go_q;
	endproperty
	a_go_stays: assert property (p_go_stays) else $error("go dropped");

	property p_repeat_clear;
		@(posedge mclk) disable iff (!arst_n)
		(first_done_q && !go_now) |=> !go_q;
	endproperty
	a_repeat_clear: assert property (p_repeat_clear)
		else $error("go set in repeat");

	property p_low_latch;
		@(posedge mclk) disable iff (!arst_n)
		(rd_upper && pready) |=> low_latch_q == $past(result_q[1:0]);
	endproperty
	a_low_latch: assert property (p_low_latch) else $error("latch");

	property p_wake;
		@(posedge mclk) disable iff (!arst_n)
		(go_now && !powered_q) |=> state_q == ADCC_WAKE;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake");

	property p_power_down;
		@(posedge mclk) disable iff (!arst_n)
		(!powered_q) |-> state_q == ADCC_IDLE || go_now;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("powered down busy");

	// checking aids, counted apart from the sequencer's own counters
	logic [ADCC_CNT_W-1:0] age_q;
	logic [5:0]            cold_q;

	// cycles since the core was last started; saturates on a long rest
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			age_q <= '0;
		end else if (core_start) begin
			age_q <= ADCC_CNT_W'(1);
		end else if (age_q != '1) begin
			age_q <= age_q + ADCC_CNT_W'(1);
		end
	end

	// cycles since a start found the converter powered down
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cold_q <= '0;
		end else if (go_now && !powered_q) begin
			cold_q <= 6'd1;
		end else if (state_q == ADCC_WAKE) begin
			cold_q <= cold_q + 6'd1;
		end
	end

	// a completion ends exactly one full interval after its start
	sequence s_single_end;
		state_q == ADCC_CONV && core_done;
	endsequence

	sequence s_period_end;
		state_q == ADCC_RPT && core_done;
	endsequence

	property p_single_len;
		@(posedge mclk) disable iff (!arst_n)
		s_single_end |-> age_q == ADCC_CNT_W'(ADCC_SINGLE_CYCLES);
	endproperty
	a_single_len: assert property (p_single_len)
		else $error("single conversion length wrong");

	property p_period_len;
		@(posedge mclk) disable iff (!arst_n)
		s_period_end |-> age_q == ADCC_CNT_W'(ADCC_REPEAT_CYCLES);
	endproperty
	a_period_len: assert property (p_period_len)
		else $error("repeat period wrong");

	// a restart during power-up cuts the wait short, so it is excluded
	property p_wake_len;
		@(posedge mclk) disable iff (!arst_n)
		(state_q == ADCC_WAKE && core_start && !go_now)
			|-> cold_q == 6'(ADCC_WAKE_CYCLES);
	endproperty
	a_wake_len: assert property (p_wake_len)
		else $error("power-up time wrong");
endmodule
`default_nettype wire
